/* File: hdl/mfq_core.sv */
// sample queue control/status and angular-rate event generator
`include "mfq_defines.svh"

// How it works
// R1 - mode 000 is reset value: queue off, pass-through
// R2 - mode 001 stores until full then stops
// R3 - mode 011 overwrites while trigger high, stop-on-full after it drops
// R4 - mode 100 pass-through while trigger high, overwrite after it drops
// R5 - mode 110 overwrites oldest sample when full
// R6 - host never writes reserved mode 010
// R7 - five-bit watermark next to mode, resets to zero
// R8 - watermark flag set when count at or above watermark
// R9 - overrun only when full and a sample overwritten; then count 32, or the watermark under depth limit
// R10 - six-bit unread count, 0 empty, 32 full
// R11 - combine enabled axis events by OR when bit 0, AND when 1
// R12 - latch bit holds the event request; else it follows the condition
// R13 - high enable raises request when rate above threshold
// R14 - low enable raises request when rate below threshold
// R15 - 15-bit signed thresholds over high and low bytes, reset zero
// R16 - x high byte msb picks duration counter reset or decrement
// R17 - host writes zero in msb of y and z high bytes
// R18 - queue works only when enabled; depth limit caps at watermark
// R19 - seven-bit duration sets minimum event persistence in samples
// R20 - trigger is the combined rate event request
// R21 - sample read frees oldest entry; status read has no side effect
module mfq_core
  import mfq_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic odr_tick_i,
  input wire logic signed [15:0] rate_x_i,
  input wire logic signed [15:0] rate_y_i,
  input wire logic signed [15:0] rate_z_i,
  input wire logic sample_pop_i,
  output logic sample_push_o,
  output logic [4:0] wr_slot_o,
  output logic [4:0] rd_slot_o,
  output logic rate_event_o
);
  // ****************************************
  // register file
  // ****************************************
  logic [7:0] qctrl_reg;
  logic [7:0] rcfg_reg;
  logic [7:0] thxh_reg, thxl_reg, thyh_reg, thyl_reg, thzh_reg, thzl_reg;
  logic [7:0] dur_reg;
  logic [1:0] qen_reg;
  logic [5:0] count_reg;
  logic [4:0] rd_ptr_reg;
  logic overrun_reg;
  logic req_reg;
  mfq_state_t state_reg;
  mfq_state_t state_next;
  mfq_mode_t mode;
  logic [4:0] watermark;
  logic [5:0] cap;
  logic full;
  logic push, pop, wrap;
  logic [2:0] hi_ev, lo_ev;
  logic [5:0] en_ev, act_ev;
  logic cond;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = reg_wr_i && (a == b);
  endfunction

  assign mode = mfq_mode_t'(qctrl_reg[`MFQ_MODE_MSB:`MFQ_MODE_LSB]);
  assign watermark = qctrl_reg[4:0];

  // host writes; all fields reset to zero
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      qctrl_reg <= `MFQ_QCTRL_RST; // R1 R7
      rcfg_reg <= 8'h00;
      thxh_reg <= 8'h00; // R15 R16
      thxl_reg <= 8'h00;
      thyh_reg <= 8'h00;
      thyl_reg <= 8'h00;
      thzh_reg <= 8'h00;
      thzl_reg <= 8'h00;
      dur_reg <= 8'h00;
      qen_reg <= 2'h0;
    end
    else
    begin
      if (hit(reg_addr_i, `MFQ_ADDR_QCTRL)) qctrl_reg <= reg_wdata_i; // R6
      if (hit(reg_addr_i, `MFQ_ADDR_RCFG)) rcfg_reg <= reg_wdata_i;
      if (hit(reg_addr_i, `MFQ_ADDR_THXH)) thxh_reg <= reg_wdata_i;
      if (hit(reg_addr_i, `MFQ_ADDR_THXL)) thxl_reg <= reg_wdata_i;
      if (hit(reg_addr_i, `MFQ_ADDR_THYH)) thyh_reg <= reg_wdata_i; // R17
      if (hit(reg_addr_i, `MFQ_ADDR_THYL)) thyl_reg <= reg_wdata_i;
      if (hit(reg_addr_i, `MFQ_ADDR_THZH)) thzh_reg <= reg_wdata_i;
      if (hit(reg_addr_i, `MFQ_ADDR_THZL)) thzl_reg <= reg_wdata_i;
      if (hit(reg_addr_i, `MFQ_ADDR_DUR)) dur_reg <= reg_wdata_i;
      if (hit(reg_addr_i, `MFQ_ADDR_QEN)) qen_reg <= reg_wdata_i[1:0];
    end
  end

  // ****************************************
  // rate event generator
  // ****************************************
  mfq_axis_cmp u_x
  (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tick_i(odr_tick_i), .rate_i(rate_x_i),
    .thresh_i({thxh_reg[6:0], thxl_reg}), .dur_i(dur_reg[6:0]),
    .decr_i(thxh_reg[`MFQ_DECR_BIT]), .high_o(hi_ev[0]), .low_o(lo_ev[0])
  );
  mfq_axis_cmp u_y
  (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tick_i(odr_tick_i), .rate_i(rate_y_i),
    .thresh_i({thyh_reg[6:0], thyl_reg}), .dur_i(dur_reg[6:0]),
    .decr_i(thxh_reg[`MFQ_DECR_BIT]), .high_o(hi_ev[1]), .low_o(lo_ev[1])
  );
  mfq_axis_cmp u_z
  (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tick_i(odr_tick_i), .rate_i(rate_z_i),
    .thresh_i({thzh_reg[6:0], thzl_reg}), .dur_i(dur_reg[6:0]),
    .decr_i(thxh_reg[`MFQ_DECR_BIT]), .high_o(hi_ev[2]), .low_o(lo_ev[2])
  );

  // enable bits: 0 x-low,1 x-high,2 y-low,3 y-high,4 z-low,5 z-high
  assign en_ev = rcfg_reg[5:0];
  assign act_ev = {hi_ev[2], lo_ev[2], hi_ev[1], lo_ev[1], hi_ev[0], lo_ev[0]} & en_ev;
  // and needs every enabled event; or needs any
  assign cond = (en_ev != 6'h00) &&
    (rcfg_reg[`MFQ_ANDOR_BIT] ? (act_ev == en_ev) : (act_ev != 6'h00)); // R11

  // request: latched until config rewritten, else follows
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      req_reg <= 1'b0;
    else if (odr_tick_i && cond)
      req_reg <= 1'b1;
    else if (hit(reg_addr_i, `MFQ_ADDR_RCFG))
      req_reg <= 1'b0;
    else if (odr_tick_i && !rcfg_reg[`MFQ_LATCH_BIT])
      req_reg <= 1'b0; // R12
  end

  // ****************************************
  // queue mode machine
  // ****************************************
  always_comb
  begin
    state_next = MFQ_QS_OFF;
    if (qen_reg[`MFQ_QEN_BIT]) // R18
    begin
      case (mode)
        MFQ_FIFO: state_next = MFQ_QS_STOP; // R2
        MFQ_CONT_FIFO: state_next = req_reg ? MFQ_QS_WRAP : MFQ_QS_STOP; // R3 R20
        MFQ_BYP_CONT: state_next = req_reg ? MFQ_QS_OFF : MFQ_QS_WRAP; // R4 R20
        MFQ_CONT: state_next = MFQ_QS_WRAP; // R5
        default: state_next = MFQ_QS_OFF; // R1
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      state_reg <= MFQ_QS_OFF;
    else
      state_reg <= state_next;
  end

  // ****************************************
  // queue pointers and status
  // ****************************************
  assign cap = (qen_reg[`MFQ_DLIM_BIT] && watermark != 5'h00) ? {1'b0, watermark}
    : `MFQ_DEPTH; // R18
  assign full = count_reg >= cap;
  assign push = odr_tick_i && (state_reg != MFQ_QS_OFF) &&
    (!full || state_reg == MFQ_QS_WRAP);
  assign wrap = push && full;
  // no pop while the queue is off: the count is being flushed then
  assign pop = sample_pop_i && (state_reg != MFQ_QS_OFF) && (count_reg != 6'h00) && !wrap;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || state_reg == MFQ_QS_OFF)
    begin
      count_reg <= 6'h00;
      rd_ptr_reg <= 5'h00;
      overrun_reg <= 1'b0;
    end
    else
    begin
      if (wrap)
      begin
        rd_ptr_reg <= rd_ptr_reg + 5'h01; // R5
        overrun_reg <= 1'b1; // R9
      end
      else if (push && !pop)
        count_reg <= count_reg + 6'h01; // R10
      else if (pop && !push)
      begin
        count_reg <= count_reg - 6'h01; // R21
        rd_ptr_reg <= rd_ptr_reg + 5'h01;
        overrun_reg <= 1'b0;
      end
      else if (pop)
        rd_ptr_reg <= rd_ptr_reg + 5'h01;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sample_push_o <= 1'b0;
      wr_slot_o <= 5'h00;
      rd_slot_o <= 5'h00;
      rate_event_o <= 1'b0;
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      sample_push_o <= push;
      wr_slot_o <= rd_ptr_reg + count_reg[4:0];
      rd_slot_o <= rd_ptr_reg;
      rate_event_o <= req_reg;
      // read data is pure: no read side effects
      case (reg_addr_i)
        `MFQ_ADDR_QCTRL: reg_rdata_o <= qctrl_reg;
        `MFQ_ADDR_QSTAT: reg_rdata_o <= {count_reg >= {1'b0, watermark}, overrun_reg,
          count_reg}; // R8 R9 R21
        `MFQ_ADDR_RCFG: reg_rdata_o <= rcfg_reg;
        `MFQ_ADDR_THXH: reg_rdata_o <= thxh_reg;
        `MFQ_ADDR_THXL: reg_rdata_o <= thxl_reg;
        `MFQ_ADDR_THYH: reg_rdata_o <= thyh_reg;
        `MFQ_ADDR_THYL: reg_rdata_o <= thyl_reg;
        `MFQ_ADDR_THZH: reg_rdata_o <= thzh_reg;
        `MFQ_ADDR_THZL: reg_rdata_o <= thzl_reg;
        `MFQ_ADDR_DUR: reg_rdata_o <= dur_reg;
        `MFQ_ADDR_QEN: reg_rdata_o <= {6'h00, qen_reg};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_bypass;
    @(posedge clk_i) disable iff (sys_rst_i)
    (mode == MFQ_BYPASS) |=> (state_reg == MFQ_QS_OFF) ##1 (count_reg == 6'h00);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass keeps queue"); // R1
  property p_stop_full;
    @(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == MFQ_QS_STOP && full) |-> !push;
  endproperty
  a_stop_full: assert property (p_stop_full) else $error("push when full"); // R2
  property p_mixed3;
    @(posedge clk_i) disable iff (sys_rst_i)
    (qen_reg[1] && mode == MFQ_CONT_FIFO && !req_reg) |=> (state_reg == MFQ_QS_STOP);
  endproperty
  a_mixed3: assert property (p_mixed3) else $error("mode 3 wrong"); // R3
  property p_mixed4;
    @(posedge clk_i) disable iff (sys_rst_i)
    (qen_reg[1] && mode == MFQ_BYP_CONT && req_reg) |=> (state_reg == MFQ_QS_OFF);
  endproperty
  a_mixed4: assert property (p_mixed4) else $error("mode 4 wrong"); // R4
  property p_wrap;
    @(posedge clk_i) disable iff (sys_rst_i)
    (wrap && state_reg == $past(state_reg)) |=> overrun_reg && count_reg == $past(count_reg);
  endproperty
  a_wrap: assert property (p_wrap) else $error("overwrite lost"); // R5 R9
  property p_count_max;
    @(posedge clk_i) disable iff (sys_rst_i)
    count_reg <= `MFQ_DEPTH;
  endproperty
  a_count_max: assert property (p_count_max) else $error("count above 32"); // R10
  property p_pop;
    @(posedge clk_i) disable iff (sys_rst_i)
    (pop && !push && state_next == state_reg) |=> count_reg == $past(count_reg) - 6'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop count"); // R21
  property p_latch;
    @(posedge clk_i) disable iff (sys_rst_i)
    (req_reg && rcfg_reg[`MFQ_LATCH_BIT] && !reg_wr_i) |=> req_reg;
  endproperty
  a_latch: assert property (p_latch) else $error("latch dropped"); // R12
  property p_overrun_full;
    @(posedge clk_i) disable iff (sys_rst_i)
    (overrun_reg && !qen_reg[`MFQ_DLIM_BIT]) |-> (count_reg == `MFQ_DEPTH);
  endproperty
  a_overrun_full: assert property (p_overrun_full) else $error("overrun below full"); // R9
  property p_follow;
    @(posedge clk_i) disable iff (sys_rst_i)
    (odr_tick_i && !cond && !rcfg_reg[`MFQ_LATCH_BIT]) |=> !req_reg;
  endproperty
  a_follow: assert property (p_follow) else $error("request not following"); // R12
  c_wrap: cover property (@(posedge clk_i) wrap);
  c_stop_full: cover property (@(posedge clk_i) state_reg == MFQ_QS_STOP && full);
  c_full: cover property (@(posedge clk_i) count_reg == `MFQ_DEPTH);
  c_event: cover property (@(posedge clk_i) $rose(req_reg));
endmodule // mfq_core

/* File: hdl/mfq_defines.svh */
// register offsets, field positions, reset values and limits of the motion queue block
`ifndef MFQ_DEFINES_SVH
`define MFQ_DEFINES_SVH
`define MFQ_ADDR_QCTRL 8'h2E
`define MFQ_ADDR_QSTAT 8'h2F
`define MFQ_ADDR_RCFG 8'h30
`define MFQ_ADDR_THXH 8'h31
`define MFQ_ADDR_THXL 8'h32
`define MFQ_ADDR_THYH 8'h33
`define MFQ_ADDR_THYL 8'h34
`define MFQ_ADDR_THZH 8'h35
`define MFQ_ADDR_THZL 8'h36
`define MFQ_ADDR_DUR 8'h37
`define MFQ_ADDR_QEN 8'h23
`define MFQ_DEPTH 6'h20
`define MFQ_QCTRL_RST 8'h00
`define MFQ_MODE_MSB 7
`define MFQ_MODE_LSB 5
`define MFQ_DECR_BIT 7
`define MFQ_ANDOR_BIT 7
`define MFQ_LATCH_BIT 6
`define MFQ_QEN_BIT 1
`define MFQ_DLIM_BIT 0
`endif

/* File: hdl/mfq_pkg.sv */
// types of the motion queue block
package mfq_pkg;
  typedef enum logic [2:0]
  {
    MFQ_BYPASS = 3'h0,
    MFQ_FIFO = 3'h1,
    MFQ_RSVD = 3'h2,
    MFQ_CONT_FIFO = 3'h3,
    MFQ_BYP_CONT = 3'h4,
    MFQ_CONT = 3'h6
  } mfq_mode_t;
  typedef enum logic [2:0]
  {
    MFQ_QS_OFF = 3'b001,
    MFQ_QS_STOP = 3'b010,
    MFQ_QS_WRAP = 3'b100
  } mfq_state_t;
endpackage

/* File: hdl/mfq_axis_cmp.sv */
// per-axis threshold compare with duration counter
module mfq_axis_cmp
  import mfq_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic tick_i,
  input wire logic signed [15:0] rate_i,
  input wire logic [14:0] thresh_i,
  input wire logic [6:0] dur_i,
  input wire logic decr_i,
  output logic high_o,
  output logic low_o
);
  logic signed [15:0] th_s;
  logic [6:0] hi_cnt_reg;
  logic [6:0] lo_cnt_reg;
  logic raw_hi;
  logic raw_lo;

  // sign-extend the 15-bit threshold
  assign th_s = {thresh_i[14], thresh_i};
  assign raw_hi = rate_i > th_s;
  assign raw_lo = rate_i < th_s;

  // persistence counters: event only after dur samples
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      hi_cnt_reg <= 7'h00;
      lo_cnt_reg <= 7'h00;
    end
    else if (tick_i)
    begin
      if (raw_hi)
        hi_cnt_reg <= (hi_cnt_reg == 7'h7F) ? hi_cnt_reg : hi_cnt_reg + 7'h01; // R19
      else if (decr_i && hi_cnt_reg != 7'h00)
        hi_cnt_reg <= hi_cnt_reg - 7'h01; // R16
      else
        hi_cnt_reg <= 7'h00;
      if (raw_lo)
        lo_cnt_reg <= (lo_cnt_reg == 7'h7F) ? lo_cnt_reg : lo_cnt_reg + 7'h01;
      else if (decr_i && lo_cnt_reg != 7'h00)
        lo_cnt_reg <= lo_cnt_reg - 7'h01;
      else
        lo_cnt_reg <= 7'h00;
    end
  end

  assign high_o = raw_hi && (hi_cnt_reg >= dur_i); // R13
  assign low_o = raw_lo && (lo_cnt_reg >= dur_i); // R14
endmodule // mfq_axis_cmp

/* File: tb/mfq_host_model.sv */
// host side model driving the byte register port of the motion queue block
`include "mfq_defines.svh"
module mfq_host_model
(
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // register access tasks
  // ****************************************
  initial
  begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // one-cycle write strobe, held over one rising edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr == `MFQ_ADDR_QCTRL && d[7:5] == 3'h2)
      return;
    if (addr == `MFQ_ADDR_THYH || addr == `MFQ_ADDR_THZH)
      d[7] = 1'b0;
    @(negedge clk_i);
    reg_addr_o = addr;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
  endtask
  // address held one full cycle, data taken after the registering edge
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_i);
    reg_addr_o = addr;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    data = reg_rdata_i;
    reg_rd_o = 1'b0;
  endtask
endmodule // mfq_host_model

/* File: tb/motion_fifo_and_rate_event_gen_tb_top.sv */
// self-checking bench of the motion queue and rate event block
`include "mfq_defines.svh"
module motion_fifo_and_rate_event_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr, reg_rd, odr_tick = 1'b0, sample_pop = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic signed [15:0] rate_x = 16'h0000, rate_y = 16'h0000, rate_z = 16'h0000;
  logic sample_push, rate_event;
  logic [4:0] wr_slot, rd_slot;
  int failures = 0;
  int total_checks = 0;
  int push_count = 0;
  // ****************************************
  // clock, design and host
  // ****************************************
  always #5 clk_i = ~clk_i;
  // count store pulses away from the edge that launches them
  always @(negedge clk_i)
    if (sample_push)
      push_count++;
  mfq_core dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .odr_tick_i(odr_tick), .rate_x_i(rate_x), .rate_y_i(rate_y), .rate_z_i(rate_z),
    .sample_pop_i(sample_pop), .sample_push_o(sample_push), .wr_slot_o(wr_slot),
    .rd_slot_o(rd_slot), .rate_event_o(rate_event));
  mfq_host_model host (.clk_i(clk_i), .reg_rdata_i(reg_rdata), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(addr, d);
    check(d, exp);
  endtask
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(negedge clk_i) odr_tick = 1'b1;
      @(negedge clk_i) odr_tick = 1'b0;
      repeat (2) @(negedge clk_i);
    end
  endtask
  task automatic pops(input int n);
    repeat (n)
    begin
      @(negedge clk_i) sample_pop = 1'b1;
      @(negedge clk_i) sample_pop = 1'b0;
    end
  endtask
  task automatic set_mode(input logic [7:0] qctrl);
    host.write_reg(`MFQ_ADDR_QCTRL, 8'h03); // bypass first, so the count is flushed
    host.write_reg(`MFQ_ADDR_QCTRL, qctrl);
    repeat (2) @(negedge clk_i);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    check_reg(`MFQ_ADDR_QCTRL, 8'h00);
    check_reg(`MFQ_ADDR_QSTAT, 8'h80);
    check_reg(`MFQ_ADDR_RCFG, 8'h00);
    check_reg(`MFQ_ADDR_THXH, 8'h00);
    check_reg(`MFQ_ADDR_THXL, 8'h00);
    check_reg(`MFQ_ADDR_THYH, 8'h00);
    check_reg(8'h10, 8'h00);
    host.write_reg(`MFQ_ADDR_THXH, 8'h80);
    check_reg(`MFQ_ADDR_THXH, 8'h80);
    host.write_reg(`MFQ_ADDR_THXH, 8'h00);
    $display("test_reset done");
  endtask
  task automatic test_fifo();
    host.write_reg(`MFQ_ADDR_QEN, 8'h02);
    set_mode(8'h23);
    push_count = 0;
    check_reg(`MFQ_ADDR_QCTRL, 8'h23);
    ticks(34);
    check_reg(`MFQ_ADDR_QSTAT, 8'hA0);
    check(8'(push_count), 8'h20);
    pops(30);
    check_reg(`MFQ_ADDR_QSTAT, 8'h02);
    check({3'h0, rd_slot}, 8'h1E);
    check_reg(`MFQ_ADDR_QSTAT, 8'h02);
    ticks(1);
    check_reg(`MFQ_ADDR_QSTAT, 8'h83);
    check({3'h0, wr_slot}, 8'h01);
    $display("test_fifo done");
  endtask
  task automatic test_cont();
    set_mode(8'h03);
    push_count = 0;
    ticks(2);
    check_reg(`MFQ_ADDR_QSTAT, 8'h00);
    check(8'(push_count), 8'h00);
    set_mode(8'hC3);
    push_count = 0;
    ticks(33);
    check_reg(`MFQ_ADDR_QSTAT, 8'hE0);
    check(8'(push_count), 8'h21);
    check({3'h0, rd_slot}, 8'h01);
    $display("test_cont done");
  endtask
  task automatic rate_step(input logic [15:0] rx, input logic [15:0] ry, input logic exp);
    rate_x = rx;
    rate_y = ry;
    ticks(1);
    check({7'h00, rate_event}, {7'h00, exp});
  endtask
  task automatic test_rate();
    set_mode(8'h03);
    host.write_reg(`MFQ_ADDR_THXL, 8'h64);
    host.write_reg(`MFQ_ADDR_THYL, 8'h64);
    host.write_reg(`MFQ_ADDR_RCFG, 8'h02);
    rate_step(16'h00C8, 16'h0000, 1'b1);
    rate_step(16'h0000, 16'h0000, 1'b0);
    host.write_reg(`MFQ_ADDR_RCFG, 8'h01);
    rate_step(16'hFF38, 16'h0000, 1'b1);
    host.write_reg(`MFQ_ADDR_RCFG, 8'h8A);
    rate_step(16'h00C8, 16'h0000, 1'b0);
    rate_step(16'h00C8, 16'h00C8, 1'b1);
    host.write_reg(`MFQ_ADDR_RCFG, 8'h42);
    rate_step(16'h00C8, 16'h0000, 1'b1);
    rate_step(16'h0000, 16'h0000, 1'b1);
    $display("test_rate done");
  endtask
  task automatic test_duration();
    host.write_reg(`MFQ_ADDR_DUR, 8'h02);
    host.write_reg(`MFQ_ADDR_RCFG, 8'h02);
    rate_step(16'h00C8, 16'h0000, 1'b0);
    rate_step(16'h00C8, 16'h0000, 1'b0);
    rate_step(16'h00C8, 16'h0000, 1'b1);
    host.write_reg(`MFQ_ADDR_THXH, 8'h80);
    rate_step(16'h0000, 16'h0000, 1'b0);
    rate_step(16'h00C8, 16'h0000, 1'b1);
    host.write_reg(`MFQ_ADDR_THXH, 8'h00);
    rate_step(16'h0000, 16'h0000, 1'b0);
    rate_step(16'h00C8, 16'h0000, 1'b0);
    host.write_reg(`MFQ_ADDR_DUR, 8'h00);
    $display("test_duration done");
  endtask
  task automatic test_trigger();
    host.write_reg(`MFQ_ADDR_RCFG, 8'h02);
    rate_x = 16'h00C8;
    set_mode(8'h83);
    ticks(3);
    check_reg(`MFQ_ADDR_QSTAT, 8'h00);
    rate_x = 16'h0000;
    ticks(40);
    check_reg(`MFQ_ADDR_QSTAT, 8'hE0);
    rate_x = 16'h00C8;
    set_mode(8'h63);
    ticks(40);
    check_reg(`MFQ_ADDR_QSTAT, 8'hE0);
    $display("test_trigger done");
  endtask
  // ****************************************
  // verdict and main sequence
  // ****************************************
  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    failures++;
    conclude();
  end
  initial
  begin
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    test_reset();
    test_fifo();
    test_cont();
    test_rate();
    test_duration();
    test_trigger();
    conclude();
  end
endmodule // motion_fifo_and_rate_event_gen_tb_top
